/* File: hw/mode_dac_defines.vh */
`ifndef MODE_DAC_DEFINES_VH
`define MODE_DAC_DEFINES_VH
// APB byte offsets
`define OFF_CONFIG 12'h000
`define OFF_RAW 12'h004
`define OFF_GAIN 12'h008
`define OFF_OFFSET 12'h00C
`define OFF_STATUS 12'h010
`define OFF_LEVEL 12'h014
`define OFF_LOWER 12'h018
`define OFF_UPPER 12'h01C
// Channel configuration fields
`define CFG_SEL_HI 20
`define CFG_SEL_LO 19
`define CFG_RANGE_HI 17
`define CFG_RANGE_LO 15
`define CFG_RESET 32'h0001E000
// Force modes (drive_sel_hi, drive_sel_lo)
`define MODE_AMPS 2'h0
`define MODE_VOLTS 2'h1
`define MODE_HIZ_AMPS 2'h2
`define MODE_HIZ_VOLTS 2'h3
// DAC functions
`define FN_LEVEL 2'h0
`define FN_LOWER 2'h1
`define FN_UPPER 2'h2
// Raw write word fields: function, volts flag, range, data
`define RAW_FN_HI 21
`define RAW_FN_LO 20
`define RAW_VOLTS 19
`define RAW_RANGE_HI 18
`define RAW_RANGE_LO 16
// Reset values
`define GAIN_RESET 16'hFFFF
`define OFFSET_RESET 16'h8000
`define LEVEL_RESET 16'h8000
`define LOWER_RESET 16'h0000
`define UPPER_RESET 16'hFFFF
`define OFFSET_MID 17'h08000
`endif

/* File: hw/trim_store.v */
`timescale 1ns/1ns
`default_nettype none
// Trimmed word store, one word per address, registered read data
module trim_store #(
  parameter AW = 6,
  parameter DW = 16
) (
  input wire clock, // System clock
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Write index
  input wire [DW-1:0] wr_data, // Write word
  input wire [AW-1:0] rd_addr, // Read index
  output reg [DW-1:0] rd_data // Registered read word
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write-first is not needed; commit waits a cycle after writes
  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* File: hw/mode_dac_update.v */
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "mode_dac_defines.vh"
//
// Contract
// - Separate raw word per range in current mode; one voltage word for all ranges
// - Every raw write computes stored trimmed word
// - Mode select applies switches; drive modes load DACs
// - Config bits 20,19 pick high-Z, open switch
// - High-Z mode commits clamp writes and level writes of its own drive mode
// - High-Z volts level write caches and loads
// - Current clamps trimmed and loaded in volts
// - Other-mode raw write only updates store
module mode_dac_update #(
  parameter RANGES = 8
) (
  input wire clock, // 20 MHz clock
  input wire rst_n, // Synchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  output reg output_switch, // Force amplifier switch closed
  output reg drive_volts_state, // Voltage drive selected
  output reg drive_amps_state, // Current drive selected
  output reg [15:0] level_drive_dac, // Level DAC register
  output reg [15:0] lower_clamp_dac, // Lower clamp DAC register
  output reg [15:0] upper_clamp_dac // Upper clamp DAC register
);
  localparam ST_IDLE = 3'h0;
  localparam ST_TRIM = 3'h1;
  localparam ST_LOAD0 = 3'h2;
  localparam ST_LOAD1 = 3'h3;
  localparam ST_LOAD2 = 3'h4;
  localparam ST_LOAD3 = 3'h5;
  localparam ST_LOAD4 = 3'h6;

  reg [31:0] config_reg;
  reg [15:0] gain_reg;
  reg [15:0] offset_reg;
  reg [21:0] raw_level_word;
  reg [2:0] state_reg;
  reg [15:0] trimmed_level_word;
  reg [5:0] wr_addr_reg;
  reg store_wr_reg;
  reg [5:0] rd_addr_reg;
  wire [15:0] rd_data;
  wire [1:0] mode_sel;
  wire [2:0] range_sel;
  wire [1:0] raw_fn;
  wire raw_volts;
  wire [2:0] raw_range;
  wire raw_live;
  wire access;
  wire busy;
  wire [32:0] product;
  wire [17:0] trim_sum;
  reg [31:0] rd_mux;
  reg addr_ok;

  assign mode_sel = config_reg[`CFG_SEL_HI:`CFG_SEL_LO];
  assign range_sel = config_reg[`CFG_RANGE_HI:`CFG_RANGE_LO];
  assign raw_fn = raw_level_word[`RAW_FN_HI:`RAW_FN_LO];
  assign raw_volts = raw_level_word[`RAW_VOLTS];
  assign raw_range = raw_level_word[`RAW_RANGE_HI:`RAW_RANGE_LO];
  assign access = psel & penable;
  assign busy = (state_reg != ST_IDLE);

  // Gain then offset: x*(m+1)/2^16 + c - 2^15, saturated to 16 bits
  assign product = {1'b0, raw_level_word[15:0]} *
                   ({1'b0, gain_reg} + 17'h00001);
  assign trim_sum = {2'h0, product[31:16]} + {2'h0, offset_reg};

  // Raw word is live if it matches the selected mode, and the range unless a voltage level
  // Clamps are current words, live only in voltage drive
  assign raw_live = (raw_fn == `FN_LEVEL) ?
    ((raw_volts == mode_sel[0]) &&
     (raw_volts || (raw_range == range_sel))) :
    (mode_sel[0] && !raw_volts && (raw_range == range_sel));

  // Store index: function, volts flag, range (range zero for volts words)
  function [5:0] store_index;
    input [1:0] fn;
    input volts;
    input [2:0] rng;
    begin
      store_index = {fn, (fn == `FN_LEVEL) ? volts : 1'b0, rng};
      if (volts) begin
        store_index = {fn, 1'b1, 3'h0};
      end
    end
  endfunction

  // Decode of readable addresses
  always @* begin
    addr_ok = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `OFF_CONFIG: rd_mux = config_reg;
      `OFF_RAW: rd_mux = {10'h000, raw_level_word};
      `OFF_GAIN: rd_mux = {16'h0000, gain_reg};
      `OFF_OFFSET: rd_mux = {16'h0000, offset_reg};
      `OFF_STATUS: rd_mux = {29'h00000000, busy, drive_volts_state,
                             output_switch};
      `OFF_LEVEL: rd_mux = {16'h0000, level_drive_dac};
      `OFF_LOWER: rd_mux = {16'h0000, lower_clamp_dac};
      `OFF_UPPER: rd_mux = {16'h0000, upper_clamp_dac};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB slave: one wait cycle, stalls while the engine is busy
  always @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      config_reg <= `CFG_RESET;
      gain_reg <= `GAIN_RESET;
      offset_reg <= `OFFSET_RESET;
      raw_level_word <= 22'h000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (access && !pready && !busy) begin
        pready <= 1'b1;
        pslverr <= ~addr_ok;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        if (pwrite && addr_ok) begin
          case (paddr)
            `OFF_CONFIG: config_reg <= pwdata;
            `OFF_RAW: raw_level_word <= pwdata[21:0];
            `OFF_GAIN: gain_reg <= pwdata[15:0];
            `OFF_OFFSET: offset_reg <= pwdata[15:0];
            default: ;
          endcase
        end
      end
    end
  end

  // Calibration and commit engine
  always @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      store_wr_reg <= 1'b0;
      wr_addr_reg <= 6'h00;
      rd_addr_reg <= 6'h00;
      trimmed_level_word <= 16'h0000;
      output_switch <= 1'b0;
      drive_volts_state <= 1'b0;
      drive_amps_state <= 1'b0;
      level_drive_dac <= `LEVEL_RESET;
      lower_clamp_dac <= `LOWER_RESET;
      upper_clamp_dac <= `UPPER_RESET;
    end else begin
      store_wr_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (access && pready && pwrite && paddr == `OFF_RAW) begin
            state_reg <= ST_TRIM;
          end else if (access && pready && pwrite &&
                       paddr == `OFF_CONFIG) begin
            // Switches follow the new mode at once
            output_switch <= ~mode_sel[1];
            drive_volts_state <= (mode_sel == `MODE_VOLTS);
            drive_amps_state <= (mode_sel == `MODE_AMPS);
            rd_addr_reg <= store_index(`FN_LEVEL, mode_sel[0],
                                       range_sel);
            // High-Z keeps the preloaded outputs, avoiding a glitch
            state_reg <= mode_sel[1] ? ST_IDLE : ST_LOAD0;
          end
        end
        ST_TRIM: begin
          // Saturate below zero and above full scale
          if (trim_sum < {1'b0, `OFFSET_MID}) begin
            trimmed_level_word <= 16'h0000;
          end else if (trim_sum > 18'h17FFF) begin
            // Above full scale once the midscale bias is removed
            trimmed_level_word <= 16'hFFFF;
          end else begin
            trimmed_level_word <= trim_sum[15:0] - 16'h8000;
          end
          store_wr_reg <= 1'b1;
          wr_addr_reg <= store_index(raw_fn, raw_volts, raw_range);
          state_reg <= ST_LOAD3;
        end
        ST_LOAD3: begin
          // Live words, or high-Z clamp writes and matching level writes, reach the DAC now
          if (raw_live || mode_sel[1]) begin
            if ((raw_fn == `FN_LEVEL) &&
                (!mode_sel[1] || raw_volts == mode_sel[0])) begin
              level_drive_dac <= trimmed_level_word;
            end else if (raw_fn == `FN_LOWER) begin
              lower_clamp_dac <= trimmed_level_word;
            end else if (raw_fn == `FN_UPPER) begin
              upper_clamp_dac <= trimmed_level_word;
            end
          end
          state_reg <= ST_IDLE;
        end
        ST_LOAD0: begin
          rd_addr_reg <= store_index(`FN_LOWER, 1'b0, range_sel);
          state_reg <= ST_LOAD1;
        end
        ST_LOAD1: begin
          level_drive_dac <= rd_data;
          rd_addr_reg <= store_index(`FN_UPPER, 1'b0, range_sel);
          state_reg <= ST_LOAD2;
        end
        ST_LOAD2: begin
          // Clamps only matter in voltage drive
          if (mode_sel[0]) begin
            lower_clamp_dac <= rd_data;
          end
          state_reg <= ST_LOAD4;
        end
        ST_LOAD4: begin
          if (mode_sel[0]) begin
            upper_clamp_dac <= rd_data;
          end
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  trim_store #(
    .AW(6),
    .DW(16)
  ) trim_store_inst (
    .clock(clock),
    .wr_en(store_wr_reg),
    .wr_addr(wr_addr_reg),
    .wr_data(trimmed_level_word),
    .rd_addr(rd_addr_reg),
    .rd_data(rd_data)
  );
endmodule
`default_nettype wire

/* File: dv/apb_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Host on the register bus; one transfer at a time
module apb_host (
  input wire logic clock, // Clock
  output logic psel, // Select
  output logic penable, // Enable
  output logic pwrite, // Direction
  output logic [11:0] paddr, // Address
  output logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr // Error
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // Request held until ready; released address and data are inverted so stale
  // values never pass for a live request
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: dv/mode_dac_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module mode_dac_sva (
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic output_switch, // Switch
  input wire logic drive_volts_state, // Volts
  input wire logic drive_amps_state, // Amps
  input wire logic [15:0] level_drive_dac, // Level
  input wire logic [15:0] lower_clamp_dac, // Lower
  input wire logic [15:0] upper_clamp_dac // Upper
);
  logic [3:0] since_wr;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Edges since last write; saturates so idle drift is caught
  always_ff @(posedge clock) begin
    if (!rst_n) since_wr <= 4'hF;
    else if (pready && pwrite) since_wr <= 4'h0;
    else if (since_wr != 4'hF) since_wr <= since_wr + 4'h1;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_wait; s_setup ##1 s_access |-> !pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && psel && penable; endproperty
  property p_excl; !(drive_volts_state && drive_amps_state); endproperty
  property p_open; output_switch |-> drive_volts_state || drive_amps_state;
  endproperty
  property p_rst; $rose(rst_n) |-> level_drive_dac == 16'h8000 &&
    lower_clamp_dac == 16'h0000 && upper_clamp_dac == 16'hFFFF; endproperty
  property p_sw; $changed(output_switch) || $changed(drive_volts_state)
    |-> since_wr <= 4'h2; endproperty
  property p_dac; $changed(level_drive_dac) || $changed(lower_clamp_dac) ||
    $changed(upper_clamp_dac) |-> since_wr <= 4'h7; endproperty
  a_wait: assert property (p_wait)
    else $error("ready in first access cycle");
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  a_err: assert property (p_err)
    else $error("error outside an answer");
  a_excl: assert property (p_excl)
    else $error("both drive states set");
  a_open: assert property (p_open)
    else $error("switch closed without drive");
  a_rst: assert property (p_rst)
    else $error("wrong DAC reset value");
  a_sw: assert property (p_sw)
    else $error("switch moved without a write");
  a_dac: assert property (p_dac)
    else $error("DAC moved without a write");
endmodule
bind mode_dac_update mode_dac_sva mode_dac_sva_inst (.clock(clock),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .output_switch(output_switch),
  .drive_volts_state(drive_volts_state), .drive_amps_state(drive_amps_state),
  .level_drive_dac(level_drive_dac), .lower_clamp_dac(lower_clamp_dac),
  .upper_clamp_dac(upper_clamp_dac));
`default_nettype wire

/* File: dv/pmu_mode_change_dac_update_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mode_dac_defines.vh"
module pmu_mode_change_dac_update_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic output_switch, drive_volts_state, drive_amps_state;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] level_drive_dac, lower_clamp_dac, upper_clamp_dac, x, y;
  logic [2:0] rng;
  int num_errors = 0;
  int checked = 0;
  // Free-running clock
  always #25 clock = ~clock;
  mode_dac_update mode_dac_update_inst (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_switch(output_switch), .drive_volts_state(drive_volts_state),
    .drive_amps_state(drive_amps_state), .level_drive_dac(level_drive_dac),
    .lower_clamp_dac(lower_clamp_dac), .upper_clamp_dac(upper_clamp_dac));
  apb_host apb_host_inst (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Longest update lands 5 edges after the answer, so 8 is settled
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb_host_inst.xfer(1'b1, a, d, rd, err);
    repeat (8) @(posedge clock);
  endtask
  function logic [31:0] cfg(input logic [1:0] m, input logic [2:0] r);
    return {11'h000, m, 1'b0, r, 15'h0000};
  endfunction
  function logic [31:0] raw(input logic [1:0] f, input logic v,
      input logic [2:0] r, input logic [15:0] d);
    return {10'h000, f, v, r, d};
  endfunction
  // Offset held at midscale, so only the gain scales the word
  function logic [15:0] trim(input logic [15:0] v, input logic [15:0] m);
    logic [32:0] p;
    p = {17'h00000, v} * {17'h00000, m} + {17'h00000, v};
    return p[31:16];
  endfunction
  // Main sequence
  initial begin
    void'($urandom(32'hB0B3));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    x = 16'($urandom);
    y = 16'($urandom);
    rng = 3'($urandom);
    @(posedge clock);
    check({15'h0000, output_switch}, 16'h0000);
    wr(`OFF_CONFIG, cfg(`MODE_VOLTS, rng));
    check({13'h0, output_switch, drive_volts_state, drive_amps_state},
      16'h0006);
    wr(`OFF_RAW, raw(`FN_LEVEL, 1'b1, rng, x));
    check(level_drive_dac, x);
    wr(`OFF_RAW, raw(`FN_LEVEL, 1'b0, rng, y));
    check(level_drive_dac, x);
    wr(`OFF_CONFIG, cfg(`MODE_AMPS, rng));
    check(level_drive_dac, y);
    check({13'h0, output_switch, drive_volts_state, drive_amps_state},
      16'h0005);
    // Preload in high impedance before the drive change
    wr(`OFF_CONFIG, cfg(`MODE_HIZ_VOLTS, rng));
    check({15'h0000, output_switch}, 16'h0000);
    wr(`OFF_GAIN, 32'h00007FFF);
    wr(`OFF_RAW, raw(`FN_LEVEL, 1'b1, rng, x));
    check(level_drive_dac, trim(x, 16'h7FFF));
    wr(`OFF_RAW, raw(`FN_LOWER, 1'b0, rng, y));
    check(lower_clamp_dac, trim(y, 16'h7FFF));
    wr(`OFF_RAW, raw(`FN_UPPER, 1'b0, rng, 16'hFFFF));
    check(upper_clamp_dac, 16'h7FFF);
    wr(`OFF_CONFIG, cfg(`MODE_VOLTS, rng));
    check(level_drive_dac, trim(x, 16'h7FFF));
    // Random live writes in voltage drive
    repeat (4) begin
      x = 16'($urandom);
      wr(`OFF_RAW, raw(`FN_LEVEL, 1'b1, rng, x));
      check(level_drive_dac, trim(x, 16'h7FFF));
    end
    // Read back the live level register over the bus
    apb_host_inst.xfer(1'b0, `OFF_LEVEL, 32'h00000000, rd, err);
    check(rd[15:0], trim(x, 16'h7FFF));
    apb_host_inst.xfer(1'b0, 12'h020, 32'h00000000, rd, err);
    check({15'h0000, err}, 16'h0001);
    check(rd[31:16] | rd[15:0], 16'h0000);
    stop_test;
  end
  // About 190 cycles expected; the limit leaves ample margin
  initial begin
    repeat (4000) @(posedge clock);
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
